// ==== src/tcr_timer.sv ====
// 16-bit timer with reload, four compare outputs and an APB register port.
// Assumes clock is the oscillator clock and gate and trigger pins are asynchronous.
// Operation
// - Sixteen-bit counter; rollover from all ones sets the overflow flag.
// - Timer mode counts at one sixth or one twelfth of oscillator rate.
// - Gated mode counts only while the gate pin is high.
// - Gated mode samples the gate pin once per machine cycle.
// - Event mode counts falling edges sampled per machine cycle, two cycles to detect.
// - Reload mode 0 loads the reload value on rollover and sets overflow.
// - Reload mode 1 loads the reload value on a trigger falling edge.
// - With external reload enabled, a trigger falling edge sets its flag.
// - Each compare register is matched against the counter, driving its pin.
// - Four compare channels act as 16-bit pulse-width outputs.
// - Compare mode 0 sets the pin on match and clears it on overflow.
// - In compare mode 0 software port writes reach only the shadow latch, not the pin.
// - Compare mode 1 writes a shadow latch, copied to the pin on match.
`timescale 1ns/100ps
`default_nettype none
module tcr_timer (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins.
  input wire logic gate_count_pin,
  input wire logic reload_trigger_pin,
  output logic [tcr_pkg::NUM_CMP-1:0] cmp_out,
  // Interrupt.
  output logic irq
);
  import tcr_pkg::*;

  // Register index of an address, or a value past the map when unmapped.
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = 4'hF;
    if (addr[1:0] == 2'h0 && addr <= OFF_IRQ_ENABLE_REG_ONE)
      idx = 4'(addr[7:2]);
    return idx;
  endfunction

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction

  // One-to-zero transition between two successive machine-cycle samples.
  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  localparam logic [3:0] IDX_CTRL = 4'(OFF_TIMER_TWO_CONTROL >> 2);
  localparam logic [3:0] IDX_RELOAD = 4'(OFF_RELOAD >> 2);
  localparam logic [3:0] IDX_COUNT = 4'(OFF_COUNT >> 2);
  localparam logic [3:0] IDX_CMP = 4'(OFF_CMP_BASE >> 2);
  localparam logic [3:0] IDX_PORT = 4'(OFF_PORT >> 2);
  localparam logic [3:0] IDX_STATUS = 4'(OFF_IRQ_REQUEST_REG >> 2);
  localparam logic [3:0] IDX_MASK = 4'(OFF_IRQ_ENABLE_REG_ONE >> 2);

  tcr_ctrl_t timer_two_control;
  logic [15:0] reload;
  logic [15:0] cmp [NUM_CMP];
  logic [15:0] count;
  tcr_status_t irq_request_reg;
  tcr_status_t irq_enable_reg_one;
  tcr_status_t read_status;
  logic [NUM_CMP-1:0] port_latch;
  logic [NUM_CMP-1:0] shadow;
  logic [NUM_CMP-1:0] eq;
  logic [NUM_CMP-1:0] eq_d;
  logic [NUM_CMP-1:0] match;
  logic [1:0] pin_level;
  logic [2:0] mc_phase;
  logic mc_tick;
  logic half;
  logic gate_smp;
  logic gate_prev;
  logic trig_smp;
  logic trig_prev;
  logic tick;
  logic ovf_now;
  logic trig_fall;
  logic setup;
  logic access;
  logic wr;
  logic [3:0] idx;
  logic [3:0] acc_idx;
  logic [31:0] wmerge;

  tcr_pin_sync #(
    .WIDTH(2)
  ) tcr_pin_sync_inst (
    .clock(clock),
    .reset(reset),
    .pin({reload_trigger_pin, gate_count_pin}),
    .level(pin_level)
  );

  // Bus decode. The slave never waits, so every access ends in its first access cycle.
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign idx = reg_index(paddr);
  assign acc_idx = access ? idx : 4'hF;
  assign wr = access && pwrite;
  assign pslverr = access && (idx == 4'hF);

  // Machine-cycle sequencer: a one-clock tick every six oscillator periods.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      mc_phase <= '0;
    else if (mc_phase == MC_LAST)
      mc_phase <= '0;
    else
      mc_phase <= mc_phase + 3'h1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      mc_tick <= 1'b0;
    else
      mc_tick <= (mc_phase == MC_LAST);
  end

  // Pins are sampled once per machine cycle, the previous sample kept for edges.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      gate_smp <= 1'b0;
      gate_prev <= 1'b0;
      trig_smp <= 1'b0;
      trig_prev <= 1'b0;
    end
    else if (mc_phase == MC_LAST)
    begin
      gate_smp <= pin_level[0];
      gate_prev <= gate_smp;
      trig_smp <= pin_level[1];
      trig_prev <= trig_smp;
    end
  end

  // Divide-by-two of the machine-cycle rate for the slow prescale.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      half <= 1'b0;
    else if (mc_tick)
      half <= !half;
  end

  // Count enable. Event edges need two samples, so two machine cycles per count at most.
  always_comb
  begin
    tick = 1'b0;
    case (timer_two_control.input_sel)
      TCR_IN_TIMER: tick = mc_tick && (!timer_two_control.prescale_12 || half);
      TCR_IN_GATED: tick = mc_tick && (!timer_two_control.prescale_12 || half)
                           && gate_smp;
      TCR_IN_EVENT: tick = mc_tick && fell(gate_prev, gate_smp);
      default: tick = 1'b0;
    endcase
  end

  assign ovf_now = tick && (count == CNT_MAX);
  assign trig_fall = mc_tick && fell(trig_prev, trig_smp);
  assign wmerge = merge(32'h0, pwdata, pstrb);

  // Counter. A software write wins over hardware so a preset is never lost.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      count <= '0;
    else if (wr && acc_idx == IDX_COUNT)
      count <= 16'(merge({16'h0, count}, pwdata, pstrb));
    else if (timer_two_control.reload_en && timer_two_control.reload_pin_mode && trig_fall)
      count <= reload;
    else if (ovf_now && timer_two_control.reload_en && !timer_two_control.reload_pin_mode)
      count <= reload;
    else if (tick)
      count <= count + 16'h1;
  end

  // Control, reload, compare and mask registers.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      timer_two_control <= CTRL_RST;
      reload <= RELOAD_RST;
      irq_enable_reg_one <= STAT_RST;
      for (int i = 0; i < NUM_CMP; i++)
        cmp[i] <= CMP_RST;
    end
    else if (wr)
    begin
      if (acc_idx == IDX_CTRL)
        timer_two_control <= tcr_ctrl_t'(CTRL_W'(merge(32'(timer_two_control), pwdata, pstrb)));
      if (acc_idx == IDX_RELOAD)
        reload <= 16'(merge({16'h0, reload}, pwdata, pstrb));
      if (acc_idx == IDX_MASK)
        irq_enable_reg_one <= tcr_status_t'(STAT_W'(wmerge));
      for (int i = 0; i < NUM_CMP; i++)
      begin
        if (acc_idx == IDX_CMP + 4'(i))
          cmp[i] <= 16'(merge({16'h0, cmp[i]}, pwdata, pstrb));
      end
    end
  end

  // Compare: a match is the first cycle the counter equals a compare value.
  always_comb
  begin
    for (int i = 0; i < NUM_CMP; i++)
    begin
      eq[i] = (count == cmp[i]);
      match[i] = timer_two_control.cmp_en[i] && eq[i] && !eq_d[i];
    end
  end

  // Equality history resets high so that reset itself is not seen as a match.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      eq_d <= '1;
    else
      eq_d <= eq;
  end

  // Port latches and shadow latches of the compare pins.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      port_latch <= PORT_RST;
      shadow <= PORT_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_CMP; i++)
      begin
        if (wr && acc_idx == IDX_PORT && pstrb[0])
          shadow[i] <= pwdata[i];
        if (!timer_two_control.cmp_en[i])
        begin
          if (wr && acc_idx == IDX_PORT && pstrb[0])
            port_latch[i] <= pwdata[i];
        end
        else if (!timer_two_control.cmp_mode[i])
        begin
          // Software writes do not reach this latch while mode 0 owns it.
          if (match[i])
            port_latch[i] <= 1'b1;
          else if (ovf_now)
            port_latch[i] <= 1'b0;
        end
        else if (match[i])
          port_latch[i] <= shadow[i];
      end
    end
  end

  assign cmp_out = port_latch;

  // Sticky status. Only bits already shown to a read are cleared, and a new set wins.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      irq_request_reg <= STAT_RST;
    else
    begin
      irq_request_reg.overflow_flag <= ovf_now || (irq_request_reg.overflow_flag
        && !(access && !pwrite && acc_idx == IDX_STATUS
        && read_status.overflow_flag));
      irq_request_reg.external_reload_flag <= (trig_fall
        && timer_two_control.external_reload_enable)
        || (irq_request_reg.external_reload_flag
        && !(access && !pwrite && acc_idx == IDX_STATUS
        && read_status.external_reload_flag));
      irq_request_reg.cmp_match <= match | (irq_request_reg.cmp_match
        & ~((access && !pwrite && acc_idx == IDX_STATUS) ? read_status.cmp_match : 4'h0));
    end
  end

  // Read data is captured in the setup cycle and held through the access cycle.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      prdata <= '0;
      read_status <= STAT_RST;
    end
    else if (setup)
    begin
      prdata <= '0;
      read_status <= STAT_RST;
      case (idx)
        IDX_CTRL: prdata <= 32'(timer_two_control);
        IDX_RELOAD: prdata <= {16'h0, reload};
        IDX_COUNT: prdata <= {16'h0, count};
        IDX_PORT: prdata <= {24'h0, shadow, port_latch};
        IDX_STATUS:
        begin
          prdata <= 32'(irq_request_reg);
          read_status <= irq_request_reg;
        end
        IDX_MASK: prdata <= 32'(irq_enable_reg_one);
        default:
        begin
          for (int i = 0; i < NUM_CMP; i++)
          begin
            if (idx == IDX_CMP + 4'(i))
              prdata <= {16'h0, cmp[i]};
          end
        end
      endcase
    end
  end

  // One level interrupt, the OR of every unmasked sticky bit.
  assign irq = |(irq_request_reg & irq_enable_reg_one);

endmodule // tcr_timer
`default_nettype wire

// ==== src/tcr_pkg.sv ====
// Constants, register map and carrier types of the 16-bit reload and compare timer.
// Assumes one oscillator-rate clock and an APB register port with 32-bit data.
package tcr_pkg;

  // Counter and channel widths.
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_CMP = 4;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // One machine cycle lasts this many oscillator periods.
  localparam int unsigned MC_OSC_PERIODS = 6;
  localparam int unsigned MC_CLKS = MC_OSC_PERIODS;
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);

  // Register byte offsets on the APB port.
  localparam logic [7:0] OFF_TIMER_TWO_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RELOAD = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_BASE = 8'h0C;
  localparam logic [7:0] OFF_PORT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_REQUEST_REG = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE_REG_ONE = 8'h24;
  localparam logic [7:0] OFF_STEP = 8'h04;

  // Count input selection.
  typedef enum logic [1:0] {
    TCR_IN_STOP = 2'h0,
    TCR_IN_TIMER = 2'h1,
    TCR_IN_GATED = 2'h2,
    TCR_IN_EVENT = 2'h3
  } tcr_input_t;

  // Control register layout, bit 0 upward: input_sel, prescale_12, reload_en,
  // reload_pin_mode, external_reload_enable, cmp_en[3:0], cmp_mode[3:0].
  typedef struct packed {
    logic [3:0] cmp_mode;
    logic [3:0] cmp_en;
    logic external_reload_enable;
    logic reload_pin_mode;
    logic reload_en;
    logic prescale_12;
    tcr_input_t input_sel;
  } tcr_ctrl_t;

  localparam int unsigned CTRL_W = $bits(tcr_ctrl_t);
  localparam tcr_ctrl_t CTRL_RST = '0;

  // Status and mask layout: overflow bit 0, external reload bit 1, matches 5:2.
  typedef struct packed {
    logic [3:0] cmp_match;
    logic external_reload_flag;
    logic overflow_flag;
  } tcr_status_t;

  localparam int unsigned STAT_W = $bits(tcr_status_t);
  localparam tcr_status_t STAT_RST = '0;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [3:0] PORT_RST = 4'h0;

endpackage

// ==== src/tcr_pin_sync.sv ====
// Three-stage input synchroniser with agreement filter for the timer pins.
// Assumes asynchronous pins; the output changes only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module tcr_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Pins and their clean levels.
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A level is accepted only once it has been seen twice in a row.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      level <= '0;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
      end
    end
  end

endmodule // tcr_pin_sync
`default_nettype wire

// ==== test/tcr_timer_chk.sv ====
// Port checker of the reload and compare timer.
// Assumes the bench writes whole words with all byte strobes set.
`timescale 1ns/100ps
`default_nettype none
module tcr_timer_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt.
  input wire logic gate_count_pin,
  input wire logic reload_trigger_pin,
  input wire logic [tcr_pkg::NUM_CMP-1:0] cmp_out,
  input wire logic irq
);
  import tcr_pkg::*;
  logic [13:0] ctrl_sh;
  logic [15:0] rel_sh;
  logic [5:0] mask_sh;
  logic rd_now;
  assign rd_now = psel && penable && !pwrite;
  // Byte merges are not modelled, so partial writes would confuse these copies.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ctrl_sh <= '0;
      rel_sh <= '0;
      mask_sh <= '0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == OFF_TIMER_TWO_CONTROL)
        ctrl_sh <= pwdata[13:0];
      if (paddr == OFF_RELOAD)
        rel_sh <= pwdata[15:0];
      if (paddr == OFF_IRQ_ENABLE_REG_ONE)
        mask_sh <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready low in a transfer");
  property p_unmapped;
    psel && penable && (paddr > OFF_IRQ_ENABLE_REG_ONE || paddr[1:0] != 2'h0)
      |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_irq_fall;
    $fell(irq) |-> $past(psel && penable);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without software access");
  property p_mask_off;
    mask_sh == 6'h0 |-> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high while fully masked");
  property p_clean_start;
    $fell(reset) |-> cmp_out == '0 && !irq;
  endproperty
  a_clean_start: assert property (p_clean_start)
    else $error("pins not low after reset");
  property p_ctrl_rd;
    rd_now && paddr == OFF_TIMER_TWO_CONTROL |-> prdata[13:0] == ctrl_sh;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback differs");
  property p_rel_rd;
    rd_now && paddr == OFF_RELOAD |-> prdata[15:0] == rel_sh;
  endproperty
  a_rel_rd: assert property (p_rel_rd)
    else $error("reload readback differs");
  property p_cnt_width;
    rd_now && paddr == OFF_COUNT |-> prdata[31:16] == 16'h0;
  endproperty
  a_cnt_width: assert property (p_cnt_width)
    else $error("counter wider than sixteen bits");
endmodule // tcr_timer_chk
`default_nettype wire

// ==== test/tcr_pins_model.sv ====
// Model of the external gate, event and trigger sources.
// Assumes the bench calls its tasks; levels change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module tcr_pins_model (
  // Clock.
  input wire logic clock,
  // Pins into the timer.
  output logic gate_count_pin,
  output logic reload_trigger_pin
);
  initial
  begin
    gate_count_pin = 1'b0;
    reload_trigger_pin = 1'b1;
  end
  task automatic set_gate(input logic v);
    @(posedge clock);
    gate_count_pin <= v;
  endtask
  // Two machine cycles per level leaves margin over the sampling grid.
  task automatic pulses(input int n);
    repeat (n)
    begin
      set_gate(1'b1);
      repeat (11) @(posedge clock);
      set_gate(1'b0);
      repeat (11) @(posedge clock);
    end
  endtask
  task automatic fall_trigger();
    @(posedge clock);
    reload_trigger_pin <= 1'b0;
    repeat (12) @(posedge clock);
    reload_trigger_pin <= 1'b1;
  endtask
endmodule // tcr_pins_model
`default_nettype wire

// ==== test/timer2_compare_reload_test.sv ====
// Self-checking bench of the reload and compare timer.
// Assumes the pin model drives the gate and trigger pins.
`timescale 1ns/100ps
`default_nettype none
module timer2_compare_reload_test;
  import tcr_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic gate_count_pin;
  logic reload_trigger_pin;
  logic [NUM_CMP-1:0] cmp_out;
  logic irq;
  logic [31:0] q;
  logic [31:0] v;
  int err_count = 0;
  int total_checks = 0;
  tcr_timer tcr_timer_inst (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_count_pin(gate_count_pin), .reload_trigger_pin(reload_trigger_pin),
    .cmp_out(cmp_out), .irq(irq));
  tcr_pins_model tcr_pins_model_inst (.clock(clock),
    .gate_count_pin(gate_count_pin), .reload_trigger_pin(reload_trigger_pin));
  initial
  begin
    forever #5 clock = ~clock;
  end
  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Two counter reads 120 clocks apart, a multiple of the machine cycle.
  task automatic rate(input string n, input logic [15:0] e);
    rd(OFF_COUNT);
    v = q;
    repeat (117) @(posedge clock);
    rd(OFF_COUNT);
    chk(n, 32'(q[15:0] - v[15:0]), 32'(e));
  endtask
  task automatic pin(input string n, input int i, input logic e);
    repeat (2) @(posedge clock);
    chk(n, 32'(cmp_out[i]), 32'(e));
  endtask
  task automatic t_modes();
    for (int i = 0; i < 11; i++)
    begin
      rd(8'(4 * i));
      chk("reset value", q, 32'h0);
    end
    wr(OFF_TIMER_TWO_CONTROL, 32'h1);
    rate("div6", 16'd20);
    wr(OFF_TIMER_TWO_CONTROL, 32'h5);
    rate("div12", 16'd10);
    wr(OFF_TIMER_TWO_CONTROL, 32'h2);
    repeat (12) @(posedge clock);
    rate("gate low", 16'd0);
    tcr_pins_model_inst.set_gate(1'b1);
    repeat (12) @(posedge clock);
    rate("gate high", 16'd20);
    tcr_pins_model_inst.set_gate(1'b0);
    repeat (24) @(posedge clock);
    wr(OFF_TIMER_TWO_CONTROL, 32'h3);
    wr(OFF_COUNT, 32'h0);
    tcr_pins_model_inst.pulses(5);
    repeat (40) @(posedge clock);
    rd(OFF_COUNT);
    chk("events", q, 32'h5);
  endtask
  task automatic t_overflow();
    wr(OFF_TIMER_TWO_CONTROL, 32'h0);
    wr(OFF_RELOAD, 32'hFFF0);
    wr(OFF_COUNT, 32'hFFFE);
    wr(OFF_IRQ_ENABLE_REG_ONE, 32'h1);
    rd(OFF_IRQ_REQUEST_REG);
    wr(OFF_TIMER_TWO_CONTROL, 32'h9);
    repeat (30) @(posedge clock);
    chk("irq set", 32'(irq), 32'h1);
    rd(OFF_COUNT);
    chk("reloaded", 32'(q[15:4]), 32'hFFF);
    repeat (30) @(posedge clock);
    chk("irq held", 32'(irq), 32'h1);
    rd(OFF_IRQ_REQUEST_REG);
    chk("overflow flag", 32'(q[0]), 32'h1);
    @(posedge clock);
    chk("irq cleared", 32'(irq), 32'h0);
    wr(OFF_TIMER_TWO_CONTROL, 32'h0);
    wr(OFF_IRQ_ENABLE_REG_ONE, 32'h0);
  endtask
  task automatic t_compare();
    wr(OFF_CMP_BASE, 32'h10);
    wr(OFF_COUNT, 32'h8);
    wr(OFF_TIMER_TWO_CONTROL, 32'h41);
    wr(OFF_PORT, 32'h1);
    pin("mode0 write", 0, 1'b0);
    repeat (60) @(posedge clock);
    pin("mode0 match", 0, 1'b1);
    rd(OFF_IRQ_REQUEST_REG);
    chk("match flag", 32'(q[2]), 32'h1);
    wr(OFF_COUNT, 32'hFFFE);
    repeat (30) @(posedge clock);
    pin("mode0 overflow", 0, 1'b0);
    wr(OFF_TIMER_TWO_CONTROL, 32'h0);
    wr(OFF_CMP_BASE + OFF_STEP, 32'h20);
    wr(OFF_COUNT, 32'h18);
    wr(OFF_TIMER_TWO_CONTROL, 32'h881);
    wr(OFF_PORT, 32'h2);
    pin("mode1 write", 1, 1'b0);
    rd(OFF_PORT);
    chk("shadow", 32'(q[5]), 32'h1);
    repeat (60) @(posedge clock);
    pin("mode1 match", 1, 1'b1);
    wr(OFF_TIMER_TWO_CONTROL, 32'h0);
  endtask
  // A reset after the control word is cleared, while a compare pin is high, must drop it and leave control zero.
  task automatic t_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    chk("pins after reset", 32'(cmp_out), 32'h0);
    rd(OFF_TIMER_TWO_CONTROL);
    chk("control after reset", q, 32'h0);
  endtask
  task automatic t_trigger();
    wr(OFF_RELOAD, 32'h1234);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_TIMER_TWO_CONTROL, 32'h38);
    rd(OFF_IRQ_REQUEST_REG);
    tcr_pins_model_inst.fall_trigger();
    repeat (40) @(posedge clock);
    rd(OFF_COUNT);
    chk("pin reload", q, 32'h1234);
    rd(OFF_IRQ_REQUEST_REG);
    chk("trigger flag", 32'(q[1]), 32'h1);
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    t_modes();
    t_overflow();
    t_compare();
    t_reset();
    t_trigger();
    tally_and_finish();
  end
  // Limit set at about seventeen times the expected run length.
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
endmodule // timer2_compare_reload_test
bind tcr_timer tcr_timer_chk tcr_timer_chk_inst (.clock(clock), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gate_count_pin(gate_count_pin), .reload_trigger_pin(reload_trigger_pin),
  .cmp_out(cmp_out), .irq(irq));
`default_nettype wire
